// *** logic/acr_regs.sv ***
// Purpose: APB register block for a 10-bit converter: control, channel and result registers
// Assumes: Analog core supplies a done pulse with a 10-bit value on pclk
// Notes: Zero-wait APB slave, unmapped reads return zero, pslverr stays low
//
// The register offsets and register access over APB are this design's own decisions.

`timescale 1ns/1ps
`default_nettype none

module acr_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog core
  output acr_pkg::acr_core_ctl_t core_ctl,
  output logic [15:0] analog_input_select,
  input wire acr_pkg::acr_core_res_t core_res,
  // Interrupt
  output logic irq
);
  import acr_pkg::*;

  logic [ACR_CH_W-1:0] channel_select_q;
  logic speed_q;
  logic converter_on_q;
  logic done_q;
  logic [ACR_IRQ_W-1:0] irq_status_q;
  logic [ACR_IRQ_W-1:0] irq_mask_q;
  logic [1:0] div_cnt_q;
  logic clk_en_q;
  logic [7:0] res_high;
  logic [7:0] res_low;
  logic wr_acc;
  logic rd_acc;
  logic [31:0] rdata_d;
  logic [7:0] ctrl_view;

  // Address match helper used by both read and write decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction : hit

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Result storage lives in its own module
  acr_result_store u_store (
    .pclk(pclk),
    .presetn(presetn),
    .load(core_res.done),
    .value(core_res.value),
    .res_high(res_high),
    .res_low(res_low)
  );

  // Control/status writes; reserved bit four is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_select_q <= ACR_CTRL_RST[ACR_CH_MSB:0];
      speed_q <= 1'b0;
      converter_on_q <= 1'b0;
    end else if (wr_acc && hit(paddr, ACR_OFF_CTRL)) begin
      channel_select_q <= pwdata[ACR_CH_MSB:0];
      speed_q <= pwdata[ACR_BIT_SPEED];
      converter_on_q <= pwdata[ACR_BIT_ON];
    end else if (wr_acc && hit(paddr, ACR_OFF_CHAN_SEL)) begin
      channel_select_q <= pwdata[ACR_CH_MSB:0];
    end
  end

  // Done flag: a completion in the same cycle as a clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else if (core_res.done) begin
      done_q <= 1'b1;
    end else if ((rd_acc && hit(paddr, ACR_OFF_RES_HIGH)) || (wr_acc && hit(paddr, ACR_OFF_CTRL))) begin
      done_q <= 1'b0;
    end
  end

  // Sticky interrupt status, write one to clear, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~((wr_acc && hit(paddr, ACR_OFF_IRQ_STATUS)) ?
                       pwdata[ACR_IRQ_W-1:0] : '0)) | {core_res.done};
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= '0;
    end else if (wr_acc && hit(paddr, ACR_OFF_IRQ_MASK)) begin
      irq_mask_q <= pwdata[ACR_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // Converter clock enable: one pulse every four or two CPU clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 2'h0;
      clk_en_q <= 1'b0;
    end else if (!converter_on_q) begin
      div_cnt_q <= 2'h0;
      clk_en_q <= 1'b0;
    end else if (div_cnt_q == (speed_q ? ACR_DIV_FAST : ACR_DIV_SLOW)) begin
      div_cnt_q <= 2'h0;
      clk_en_q <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 2'h1;
      clk_en_q <= 1'b0;
    end
  end

  // Core controls
  assign core_ctl.enable = converter_on_q;
  assign core_ctl.clk_en = clk_en_q;
  assign core_ctl.channel_select = channel_select_q;

  // One-hot input routing, index equals the select code
  assign analog_input_select = 16'h0001 << channel_select_q;

  assign ctrl_view = {done_q, speed_q, converter_on_q, 1'b0, channel_select_q};

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_acc) begin
      unique case (paddr)
        ACR_OFF_CTRL: rdata_d = {24'h000000, ctrl_view};
        ACR_OFF_RES_HIGH: rdata_d = {24'h000000, res_high};
        ACR_OFF_RES_LOW: rdata_d = {24'h000000, res_low};
        ACR_OFF_IRQ_STATUS: rdata_d = {31'h00000000, irq_status_q};
        ACR_OFF_IRQ_MASK: rdata_d = {31'h00000000, irq_mask_q};
        ACR_OFF_CHAN_SEL: rdata_d = {28'h0000000, channel_select_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Read data driven combinationally in the access cycle of a zero-wait read
  assign prdata = rdata_d;

endmodule : acr_regs

`default_nettype wire

// *** logic/acr_pkg.sv ***
// Purpose: Shared constants and types for the converter control and result registers
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses

package acr_pkg;

  // Register byte offsets
  localparam logic [11:0] ACR_OFF_CTRL = 12'h000;
  localparam logic [11:0] ACR_OFF_RES_HIGH = 12'h004;
  localparam logic [11:0] ACR_OFF_RES_LOW = 12'h008;
  localparam logic [11:0] ACR_OFF_IRQ_STATUS = 12'h00c;
  localparam logic [11:0] ACR_OFF_IRQ_MASK = 12'h010;
  localparam logic [11:0] ACR_OFF_CHAN_SEL = 12'h014;

  // Control/status field positions
  localparam int ACR_BIT_DONE = 7;
  localparam int ACR_BIT_SPEED = 6;
  localparam int ACR_BIT_ON = 5;
  localparam int ACR_CH_MSB = 3;

  // Widths
  localparam int ACR_RES_W = 10;
  localparam int ACR_CH_W = 4;
  localparam int ACR_REG_W = 8;

  // Reset values and divider terminal counts
  localparam logic [7:0] ACR_CTRL_RST = 8'h00;
  localparam logic [9:0] ACR_RES_RST = 10'h000;
  localparam logic [1:0] ACR_DIV_SLOW = 2'h3;
  localparam logic [1:0] ACR_DIV_FAST = 2'h1;

  // Interrupt status bits
  localparam int ACR_IRQ_DONE = 0;
  localparam int ACR_IRQ_W = 1;

  // Controls driven toward the analog core
  typedef struct packed {
    logic enable;
    logic clk_en;
    logic [3:0] channel_select;
  } acr_core_ctl_t;

  // Result handed back by the analog core
  typedef struct packed {
    logic done;
    logic [9:0] value;
  } acr_core_res_t;

endpackage : acr_pkg

// *** logic/acr_result_store.sv ***
// Purpose: Holds the last conversion result, split into high byte and low bits
// Assumes: Load is a one-cycle pulse from the analog core
// Notes: Read data come straight from flip-flops

`timescale 1ns/1ps
`default_nettype none

module acr_result_store (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Load side
  input wire logic load,
  input wire logic [acr_pkg::ACR_RES_W-1:0] value,
  // Read side
  output logic [7:0] res_high,
  output logic [7:0] res_low
);
  import acr_pkg::*;

  logic [ACR_RES_W-1:0] res_q;

  // Both halves update together on a completed conversion only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= ACR_RES_RST;
    end else if (load) begin
      res_q <= value;
    end
  end

  assign res_high = res_q[9:2];
  assign res_low = {6'h00, res_q[1:0]};

endmodule : acr_result_store

`default_nettype wire

// *** tb/acr_regs_properties.sv ***
// Purpose: Assertions on the acr_regs ports
// Assumes: Zero-wait APB, done is a one-cycle pulse
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module acr_regs_properties (
  // Watched design ports
  input wire logic pclk, presetn, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire acr_pkg::acr_core_ctl_t core_ctl,
  input wire logic [15:0] analog_input_select,
  input wire acr_pkg::acr_core_res_t core_res
);
  import acr_pkg::*;
  logic [9:0] res_q;
  // Decoded access phases
  wire d = core_res.done;
  wire rd = psel && penable && !pwrite;
  wire rh = rd && paddr == ACR_OFF_RES_HIGH;
  wire rl = rd && paddr == ACR_OFF_RES_LOW;
  wire rc = rd && paddr == ACR_OFF_CTRL;
  wire wc = psel && penable && pwrite && paddr == ACR_OFF_CTRL;
  // Last result, loaded only on done so stale values show up
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) res_q <= '0;
    else if (d) res_q <= core_res.value;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_input_route: assert property (analog_input_select == 16'h1 << core_ctl.channel_select) else $error("route");
  a_chan_write: assert property (wc |=> core_ctl.channel_select == $past(pwdata[3:0])) else $error("chan");
  a_high_read: assert property (rh |-> prdata == {24'h0, res_q[9:2]}) else $error("high");
  a_low_read: assert property (rl |-> prdata == {30'h0, res_q[1:0]}) else $error("low");
  a_done_sets: assert property (d ##1 rc |-> prdata[7]) else $error("flag set");
  a_done_clears: assert property (rh && !d ##1 !d [*2] ##1 rc |-> !prdata[7]) else $error("flag clear");
  a_off_quiet: assert property (!core_ctl.enable && !$past(core_ctl.enable) |-> !core_ctl.clk_en) else $error("off");
  a_tick_gap: assert property (core_ctl.clk_en |=> !core_ctl.clk_en) else $error("tick");
  c_done: cover property (d ##1 rc);
  c_clear: cover property (rh ##3 rc);
  c_tick: cover property (core_ctl.clk_en);
endmodule : acr_regs_properties
`default_nettype wire

// *** tb/acr_regs_test.sv ***
// Purpose: Bench for acr_regs
// Assumes: Zero-wait APB slave
// Notes: The bench drives the core side
`timescale 1ns/1ps
`default_nettype none
module acr_regs_test;
  import acr_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [15:0] analog_input_select;
  acr_core_ctl_t core_ctl;
  acr_core_res_t core_res = '0;
  int failures = 0, total_checks = 0, k, n;
  acr_regs i_dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .core_ctl(core_ctl),
    .analog_input_select(analog_input_select),
    .core_res(core_res),
    .irq(irq)
  );
  initial forever #50 pclk = ~pclk;
  task automatic report_and_stop;
    $display("checks %0d fails %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic chk(string s, logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin failures++; $display("MISMATCH %s exp %h got %h", s, e, g); end
  endtask : chk
  // One transfer, held until pready is seen at an edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    if (pready !== 1'b1) begin failures++; report_and_stop(); end
    r = prdata;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic pulse(logic [9:0] v);
    @(posedge pclk);
    core_res <= {1'b1, v};
    @(posedge pclk);
    core_res.done <= 1'b0;
  endtask : pulse
  // Reset zeros, ignored writes, no update without done
  task automatic t_res;
    apb(0, 12'h004, 0);
    chk("reset", 0, r);
    chk("slverr", 0, pslverr);
    pulse(10'h2d7);
    apb(1, 12'h008, '1);
    core_res.value <= 10'h128;
    apb(0, 12'h004, 0);
    chk("high", 32'hb5, r);
    apb(0, 12'h008, 0);
    chk("low", 32'h3, r);
  endtask : t_res
  task automatic t_chan;
    for (k = 0; k < 16; k++) begin
      apb(1, 12'h000, k);
      apb(0, 12'h000, 0);
      chk("chan", k, r);
      chk("route", 1 << k, analog_input_select);
    end
  endtask : t_chan
  // Flag set, cleared by high read and by control write
  task automatic t_done;
    fork pulse(10'h3ff); apb(0, 12'h000, 0); join
    chk("flag", 1, r[7]);
    apb(1, 12'h010, 1);
    apb(0, 12'h004, 0);
    chk("irq", 1, irq);
    apb(0, 12'h000, 0);
    chk("flag", 0, r[7]);
    apb(1, 12'h00c, 1);
    @(posedge pclk);
    chk("irq", 0, irq);
    pulse(10'h3ff);
    apb(1, 12'h000, 0);
    apb(0, 12'h000, 0);
    chk("flag", 0, r[7]);
  endtask : t_done
  // Completion in the same cycle as a high read: the set wins
  task automatic t_race;
    fork
      begin @(posedge pclk); pulse(10'h155); end
      apb(0, 12'h004, 0);
    join
    chk("high old", 32'hff, r);
    apb(0, 12'h000, 0);
    chk("flag", 1, r[7]);
    apb(0, 12'h004, 0);
    chk("high new", 32'h55, r);
  endtask : t_race
  // Reset in mid-run brings a loaded result back to zero
  task automatic t_rst;
    pulse(10'h2aa);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h004, 0);
    chk("high rst", 0, r);
    apb(0, 12'h008, 0);
    chk("low rst", 0, r);
    chk("irq rst", 0, irq);
  endtask : t_rst
  // Tick rate for divide by four, by two, then off
  task automatic t_clk;
    for (k = 0; k < 3; k++) begin
      apb(1, 12'h000, {k == 1, k < 2, 5'h0});
      repeat (4) @(posedge pclk);
      n = 0;
      repeat (16) begin @(posedge pclk); n += core_ctl.clk_en; end
      chk("ticks", k < 2 ? 4 << k : 0, n);
      chk("on", k < 2, core_ctl.enable);
    end
  endtask : t_clk
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_res();
    t_chan();
    t_done();
    t_race();
    t_clk();
    t_rst();
    report_and_stop();
  end
endmodule : acr_regs_test
bind acr_regs acr_regs_properties i_chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .core_ctl(core_ctl),
  .analog_input_select(analog_input_select),
  .core_res(core_res)
);
`default_nettype wire
